// *** csic_ext_dev.sv ***
// csic_ext_dev: external device, ends each access after dly+2 cycles
// assumes: sees the selects of csic_top
`timescale 1ns/1ps
module csic_ext_dev
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] cs_n,
   input wire logic [3:0] dly,
   output logic acc_done
);
   logic [3:0] cnt_q; // cycles selected so far
   // count selected cycles, answer once, quiet when deselected
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n || &cs_n || acc_done)
      begin
         cnt_q <= 4'h0;
         acc_done <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_q + 4'h1;
         acc_done <= (cnt_q == dly);
      end
   end
endmodule : csic_ext_dev

// *** csic_gap_calc.sv ***
// csic_gap_calc: works out idle cycles needed between two external accesses
// assumes: fed with the previous and next access and the control register
`timescale 1ns/1ps
module csic_gap_calc
   import csic_pkg::*;
(
   input wire csic_acc_t prev_acc,
   input wire csic_acc_t next_acc,
   input wire logic [CSIC_REG_W-1:0] ctrl,
   output logic [1:0] gap_cycles
);

   // pair index of a space: space modulo four
   function automatic logic [1:0] csic_pair(input logic [2:0] sp);
      csic_pair = sp[1:0];
   endfunction : csic_pair

   logic [1:0] rd_idle; // read-recovery count
   logic [1:0] b2b_idle; // back-to-back count
   logic same_pair; // both accesses in one pair
   logic rd_case; // read then write-in-pair or other pair

   // ************************************************************
   // gap decode
   // ************************************************************
   always_comb
   begin
      same_pair = (csic_pair(prev_acc.space) == csic_pair(next_acc.space));
      rd_case = !prev_acc.write && (next_acc.write || !same_pair);
      rd_idle = 2'h0;
      b2b_idle = 2'h0;
      // read-recovery fields exist for pairs 0/4 and 1/5 only
      if (rd_case && csic_pair(prev_acc.space) == 2'h1)
      begin
         rd_idle = ctrl[CSIC_F_P15_LO +: 2];
      end
      else if (rd_case && csic_pair(prev_acc.space) == 2'h0)
      begin
         rd_idle = ctrl[CSIC_F_P04_LO +: 2];
      end
      // back-to-back bits exist for pairs 2/6 and 3/7 only
      if (same_pair && csic_pair(prev_acc.space) == 2'h3 && ctrl[CSIC_F_P37_B2B])
      begin
         b2b_idle = CSIC_IDLE_ONE;
      end
      else if (same_pair && csic_pair(prev_acc.space) == 2'h2 && ctrl[CSIC_F_P26_B2B])
      begin
         b2b_idle = CSIC_IDLE_ONE;
      end
      // larger of the two counts, never the sum
      gap_cycles = (rd_idle > b2b_idle) ? rd_idle : b2b_idle;
   end

endmodule : csic_gap_calc

// *** csic_pkg.sv ***
// csic_pkg: constants, types and register layout of the idle-cycle inserter
// assumes: 32-bit AHB-Lite register bus, 200 MHz sys_clk
package csic_pkg;

   // ************************************************************
   // register map and field layout
   // ************************************************************
   localparam logic [7:0] CSIC_OFS_IDLE_CTRL = 8'h00; // bus_idle_cycle_control
   localparam logic [7:0] CSIC_OFS_STATUS = 8'h04; // idle status (read only)
   localparam int CSIC_REG_W = 16; // control register width
   localparam logic [15:0] CSIC_IDLE_CTRL_RST = 16'hFFFF; // every bit resets to one
   localparam int CSIC_F_P15_LO = 10; // pair15_read_idle_lo
   localparam int CSIC_F_P04_LO = 8; // pair04_read_idle_lo
   localparam int CSIC_F_P37_B2B = 7; // pair37_back_to_back_idle
   localparam int CSIC_F_P26_B2B = 6; // pair26_back_to_back_idle

   // ************************************************************
   // bus constants
   // ************************************************************
   localparam logic [1:0] CSIC_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] CSIC_HTRANS_SEQ = 2'h3;
   localparam int CSIC_NUM_CS = 8; // chip-select spaces
   localparam logic [1:0] CSIC_IDLE_ONE = 2'h1; // one idle cycle

   // ************************************************************
   // types
   // ************************************************************
   // an external access request from the bus engine
   typedef struct packed {
      logic [2:0] space; // chip-select space 0..7
      logic write; // 1 = write, 0 = read
   } csic_acc_t;

   // sequencer states, gray along idle -> active -> gap
   typedef enum logic [1:0] {
      CSIC_S_IDLE = 2'b00,
      CSIC_S_ACTIVE = 2'b01,
      CSIC_S_GAP = 2'b11
   } csic_state_t;

endpackage : csic_pkg

// *** csic_top.sv ***
// csic_top: idle-cycle insertion between external chip-select accesses
// assumes: AHB-Lite register slave, one access engine issuing requests
// How it works
// - after pair1/5 read, apply bits 11:10
// - pair1/5 codes give zero to three idles
// - after pair0/4 read, apply bits 9:8
// - pair0/4 codes give zero to three idles
// - bit7 inserts idle within pair 3/7
// - bit6 inserts idle within pair 2/6
// - read then write uses larger count
// - all idle bits reset to one
// - sixteen-bit readable writable control register
//
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module csic_top
   import csic_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // access request from the bus engine
   input wire logic acc_valid,
   input wire csic_acc_t acc_req,
   input wire logic acc_done,
   output logic acc_ready,
   // external strobes
   output logic [CSIC_NUM_CS-1:0] cs_n,
   output logic rd_n,
   output logic wr_n
);

   // ************************************************************
   // register slave
   // ************************************************************
   logic [CSIC_REG_W-1:0] ctrl_q, ctrl_d; // bus_idle_cycle_control
   logic wpend_q, wpend_d; // write data phase pending
   logic [7:0] waddr_q, waddr_d; // latched write address
   logic [31:0] rdata_q, rdata_d; // read data
   csic_state_t state_q, state_d; // sequencer state
   logic [1:0] gap_q, gap_d; // remaining idle cycles
   csic_acc_t prev_q, prev_d; // last completed access
   logic have_prev_q, have_prev_d; // access completed since reset or since the last withdrawn request
   csic_acc_t cur_q, cur_d; // access on the pins
   logic [1:0] gap_need; // idles needed before acc_req
   logic take; // address phase accepted
   logic [CSIC_NUM_CS-1:0] cs_n_d; // next chip selects
   logic rd_n_d; // next read strobe
   logic wr_n_d; // next write strobe

   assign hreadyout = 1'b1; // zero wait states
   assign hresp = 1'b0; // always okay
   assign hrdata = rdata_q;
   assign take = hsel && hready && (htrans == CSIC_HTRANS_NONSEQ || htrans == CSIC_HTRANS_SEQ);

   // next register values
   always_comb
   begin
      ctrl_d = ctrl_q;
      wpend_d = take && hwrite;
      waddr_d = take ? haddr : waddr_q;
      rdata_d = rdata_q;
      if (wpend_q && waddr_q == CSIC_OFS_IDLE_CTRL)
      begin
         ctrl_d = hwdata[CSIC_REG_W-1:0];
      end
      if (take && !hwrite)
      begin
         case (haddr)
            CSIC_OFS_IDLE_CTRL: rdata_d = {16'h0000, ctrl_q};
            CSIC_OFS_STATUS: rdata_d = {28'h0000000, gap_q, state_q};
            default: rdata_d = 32'h00000000; // unmapped reads zero
         endcase
      end
   end

   // register flops
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         ctrl_q <= CSIC_IDLE_CTRL_RST;
         wpend_q <= 1'b0;
         waddr_q <= 8'h00;
         rdata_q <= 32'h00000000;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         wpend_q <= wpend_d;
         waddr_q <= waddr_d;
         rdata_q <= rdata_d;
      end
   end

   // ************************************************************
   // access sequencer
   // ************************************************************
   csic_gap_calc u_gap (
      .prev_acc(prev_q),
      .next_acc(acc_req),
      .ctrl(ctrl_q),
      .gap_cycles(gap_need)
   );

   // ready when idle and no gap is owed for this request,
   // or in the last owed idle cycle, so that no extra idle follows the gap
   assign acc_ready = ((state_q == CSIC_S_IDLE) && (!have_prev_q || gap_need == 2'h0))
      || ((state_q == CSIC_S_GAP) && (gap_q == 2'h0));

   // next sequencer values
   always_comb
   begin
      state_d = state_q;
      gap_d = gap_q;
      prev_d = prev_q;
      have_prev_d = have_prev_q;
      cur_d = cur_q;
      case (state_q)
         CSIC_S_IDLE:
         begin
            if (acc_valid && acc_ready)
            begin
               cur_d = acc_req;
               state_d = CSIC_S_ACTIVE;
            end
            else if (acc_valid)
            begin
               // owed idles: strobes stay inactive meanwhile
               gap_d = gap_need - 2'h1;
               state_d = CSIC_S_GAP;
            end
         end
         CSIC_S_ACTIVE:
         begin
            if (acc_done)
            begin
               prev_d = cur_q;
               have_prev_d = 1'b1;
               state_d = CSIC_S_IDLE;
            end
         end
         CSIC_S_GAP:
         begin
            // one full clock per idle cycle; the last one may take the request
            if (gap_q != 2'h0)
            begin
               gap_d = gap_q - 2'h1;
            end
            else if (acc_valid)
            begin
               cur_d = acc_req; // gap paid, access starts next edge
               state_d = CSIC_S_ACTIVE;
            end
            else
            begin
               have_prev_d = 1'b0; // request withdrawn, gap already paid
               state_d = CSIC_S_IDLE;
            end
         end
         default: state_d = CSIC_S_IDLE;
      endcase
   end

   // ************************************************************
   // pin drive
   // ************************************************************
   // next pin values: one select and one strobe only while active,
   // so idle and gap cycles always show every pin inactive
   always_comb
   begin
      cs_n_d = '1;
      rd_n_d = 1'b1; // read strobe idle high
      wr_n_d = 1'b1; // write strobe idle high
      if (state_d == CSIC_S_ACTIVE)
      begin
         cs_n_d[cur_d.space] = 1'b0; // select of the taken space
         rd_n_d = cur_d.write; // low on a read
         wr_n_d = !cur_d.write; // low on a write
      end
   end

   // sequencer flops and pin drive
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         state_q <= CSIC_S_IDLE;
         gap_q <= 2'h0;
         prev_q <= '0;
         have_prev_q <= 1'b0;
         cur_q <= '0;
         cs_n <= '1;
         rd_n <= 1'b1;
         wr_n <= 1'b1;
      end
      else
      begin
         state_q <= state_d;
         gap_q <= gap_d;
         prev_q <= prev_d;
         have_prev_q <= have_prev_d;
         cur_q <= cur_d;
         cs_n <= cs_n_d;
         rd_n <= rd_n_d;
         wr_n <= wr_n_d;
      end
   end

endmodule : csic_top

// *** csic_top_monitor.sv ***
// csic_top_monitor: port checks of csic_top
// assumes: bound to every csic_top
`timescale 1ns/1ps
module csic_top_monitor
   import csic_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic acc_valid,
   input wire csic_acc_t acc_req,
   input wire logic acc_done,
   input wire logic acc_ready,
   input wire logic [CSIC_NUM_CS-1:0] cs_n,
   input wire logic rd_n,
   input wire logic wr_n
);
   // ****
   // checks on sys_clk
   // ****
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   rst_pins_a: assert property (disable iff (1'b0) !rst_n |=> &cs_n && rd_n && wr_n)
      else $error("pins active after reset");
   take_sel_a: assert property (acc_valid && acc_ready |=>
      !cs_n[$past(acc_req.space)] && rd_n == $past(acc_req.write))
      else $error("select or strobe wrong after take");
   done_rel_a: assert property (acc_done |=> &cs_n && rd_n && wr_n)
      else $error("pins held after done");
   busy_ready_a: assert property (!rd_n || !wr_n |-> !acc_ready)
      else $error("ready while active");
   one_sel_a: assert property (!rd_n || !wr_n |-> $onehot(~cs_n))
      else $error("not one select");
   sel_strobe_a: assert property ((rd_n && wr_n) == &cs_n)
      else $error("select without strobe");
   no_both_a: assert property (rd_n || wr_n)
      else $error("both strobes low");
   bus_okay_a: assert property (hresp == 1'b0 && hreadyout == 1'b1)
      else $error("bus answer wrong");
   upper_zero_a: assert property (hrdata[31:16] == 16'h0000)
      else $error("upper read bits set");
   cover property (acc_done ##1 &cs_n [*3]);
   cover property (!rd_n ##1 !wr_n);
   cover property (acc_valid && !acc_ready && &cs_n);
endmodule : csic_top_monitor
bind csic_top csic_top_monitor mon (.sys_clk(sys_clk), .rst_n(rst_n), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .acc_valid(acc_valid), .acc_req(acc_req), .acc_done(acc_done), .acc_ready(acc_ready),
   .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n));

// *** csic_top_tb.sv ***
// csic_top_tb: register and idle gap tests of csic_top
// assumes: package, device model and monitor compiled first
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value %s exp %h got %h", n, e, g); end end
module csic_top_tb
   import csic_pkg::*;
;
   logic sys_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, acc_valid = 0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0, hrdata, rd;
   logic hreadyout, hresp, acc_done, acc_ready, rd_n, wr_n;
   logic [7:0] cs_n;
   logic [3:0] dly = 4'h0;
   csic_acc_t acc_req = '0;
   int mismatches = 0, checks_done = 0, n;
   always #2.5 sys_clk = ~sys_clk;
   csic_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .acc_valid(acc_valid), .acc_req(acc_req), .acc_done(acc_done),
      .acc_ready(acc_ready), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n));
   csic_ext_dev dev (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .dly(dly), .acc_done(acc_done));
   // ****
   // one ahb-lite single word transfer
   // ****
   task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= CSIC_HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   // access a then b, count deselected cycles between them
   task gap(input logic [15:0] ctl, input csic_acc_t a, input csic_acc_t b, input int e);
      bus(1'b1, CSIC_OFS_IDLE_CTRL, {16'h0, ctl});
      acc_valid <= 1'b1;
      acc_req <= a;
      @(negedge sys_clk);
      while (acc_ready !== 1'b1) @(negedge sys_clk);
      @(posedge sys_clk);
      acc_req <= b;
      @(negedge sys_clk);
      n = 0;
      while (cs_n !== 8'hFF) @(negedge sys_clk);
      while (cs_n === 8'hFF)
      begin
         n++;
         @(negedge sys_clk);
      end
      @(posedge sys_clk);
      acc_valid <= 1'b0;
      `CHK("idle cycles", e + 1, n);
      while (cs_n !== 8'hFF) @(negedge sys_clk);
   endtask : gap
   task t_regs;
      bus(1'b0, CSIC_OFS_IDLE_CTRL, 32'h0);
      `CHK("ctrl reset", 32'h0000FFFF, rd);
      bus(1'b1, CSIC_OFS_IDLE_CTRL, 32'hFFFF5A3C);
      bus(1'b1, 8'h08, 32'h0);
      bus(1'b0, CSIC_OFS_IDLE_CTRL, 32'h0);
      `CHK("ctrl rw", 32'h00005A3C, rd);
      bus(1'b0, 8'h08, 32'h0);
      `CHK("unmapped", 32'h0, rd);
   endtask : t_regs
   task t_recovery;
      dly <= 4'h2;
      for (int c = 0; c < 4; c++)
      begin
         gap({4'h0, 2'(c), 10'h0}, 4'h2, 4'hB, c);
         gap({6'h0, 2'(c), 8'h0}, 4'h8, 4'h4, c);
      end
      gap(16'h0C00, 4'h2, 4'hA, 0);
   endtask : t_recovery
   task t_b2b;
      dly <= 4'h0;
      gap(16'h0080, 4'h6, 4'hE, 1);
      gap(16'h0000, 4'hE, 4'h6, 0);
      gap(16'h0040, 4'hC, 4'h4, 1);
      gap(16'h0040, 4'h4, 4'h6, 0);
      gap(16'h3040, 4'h4, 4'hD, 1);
      gap(16'h0210, 4'h0, 4'h9, 2);
   endtask : t_b2b
   task wrap_up;
      $display("mismatches %0d checks_done %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up
   initial
   begin
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_regs;
      t_recovery;
      t_b2b;
      wrap_up;
   end
   // watchdog
   initial
   begin
      #20us;
      mismatches++;
      wrap_up;
   end
endmodule : csic_top_tb
